// ==== cbw_detect.sv ====
// Purpose: Bus width detection and sync word search on the configuration data pins
// Assumes: Pins synchronous to ref_clk; config_clock sampled as a level
// Notes:   One bus word is taken per rising config_clock edge
//
// How it works
// R1 - Width search looks only at the low byte lane of the data pins.
// R2 - Mark 0xBB followed directly by 0x11 selects the 8-bit bus.
// R3 - Mark 0xBB followed directly by 0x22 selects the 16-bit bus.
// R4 - Mark 0xBB followed directly by 0x44 selects the 32-bit bus.
// R5 - Any other byte after the mark, except a repeated mark, restarts the hunt for a later mark.
// R6 - After a valid pair, capture at that width and hunt the sync word.
// R7 - Sync word 0xAA995566 in stream order fixes the 32-bit word boundary.
// R8 - No word is passed on for processing before the sync word is seen.
// R9 - In parallel modes the sync search only runs after width detection.
// R10 - After search_restart, serial, scan and serial flash modes skip width search and its bytes.
// R11 - The source sends ones, width pattern, ones, then the sync word.
// R12 - Every pin byte is bit reversed; x32 sync arrives as 0x5599AA66.
// R13 - Byte mode moves one byte per clock, stream MSB on pin zero.
// R14 - Reversal is per byte for x16 and x32 as well.
// R15 - Data is sampled once per rising config_clock edge, one bus word each.
`timescale 1ns/1ps
module cbw_detect
   import cbw_pkg::*;
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          sys_rst,
   // Mode and control
   input  wire cbw_mode_type  cfg_mode,
   input  wire logic          search_restart,
   // Configuration pins
   input  wire logic          config_clock,
   input  wire logic [31:0]   data_pins,
   // Status
   output logic               width_found,
   output cbw_width_type      bus_width,
   output logic               sync_found,
   output logic               source_ready,
   // Aligned word stream
   output logic               word_valid,
   input  wire logic          word_ready,
   output logic [31:0]        word_data
);

   cbw_core_type core_reg;
   cbw_core_type core_next;

   logic [31:0] stream_word;
   logic        clk_rise;
   logic        beat_take;
   logic        buf_ready;
   logic        serial_mode;
   logic [31:0] shifted;
   logic [5:0]  beats_needed;

   // ---------------------------------------------------------------
   // Pin bit order
   // ---------------------------------------------------------------
   // R12 R14 per-byte reversal
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_unswap
         assign stream_word[gi] = data_pins[(gi / 8) * 8 + 7 - (gi % 8)];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Beat strobe
   // ---------------------------------------------------------------
   // R15 rising edge sample
   assign clk_rise  = config_clock && !core_reg.clk_prev;
   // A held word blocks new beats while the buffer is full; the source must pause config_clock
   assign beat_take = clk_rise && !(core_reg.pend_valid && !buf_ready);

   // R10 serial class modes
   assign serial_mode = (cfg_mode == CBW_MODE_MASTER_SERIAL) ||
                        (cfg_mode == CBW_MODE_SLAVE_SERIAL)  ||
                        (cfg_mode == CBW_MODE_BOUNDARY_SCAN) ||
                        (cfg_mode == CBW_MODE_SERIAL_FLASH);

   // ---------------------------------------------------------------
   // Word assembly helpers
   // ---------------------------------------------------------------
   // R13 byte per beat in x8
   function automatic logic [31:0] shift_in(input logic [31:0] acc,
                                            input logic [31:0] beat,
                                            input cbw_width_type w);
      logic [31:0] res;
      res = acc;
      case (w)
         CBW_W_X8:  res = {acc[23:0], beat[7:0]};
         CBW_W_X16: res = {acc[15:0], beat[15:0]};
         CBW_W_X32: res = beat;
         CBW_W_X1:  res = {acc[30:0], beat[7]};
         default:   res = acc;
      endcase
      return res;
   endfunction : shift_in

   function automatic logic [5:0] beats_per_word(input cbw_width_type w);
      logic [5:0] n;
      n = CBW_BEATS_X32;
      case (w)
         CBW_W_X8:  n = CBW_BEATS_X8;
         CBW_W_X16: n = CBW_BEATS_X16;
         CBW_W_X32: n = CBW_BEATS_X32;
         CBW_W_X1:  n = CBW_BEATS_X1;
         default:   n = CBW_BEATS_X32;
      endcase
      return n;
   endfunction : beats_per_word

   assign shifted      = shift_in(core_reg.shift, stream_word, core_reg.width);
   assign beats_needed = beats_per_word(core_reg.width);

   // ---------------------------------------------------------------
   // Search and assembly state machine
   // ---------------------------------------------------------------
   always_comb
   begin
      core_next          = core_reg;
      core_next.clk_prev = config_clock;

      // Held word leaves as soon as the buffer takes it
      if (core_reg.pend_valid && buf_ready)
      begin
         core_next.pend_valid = 1'b0;
      end

      if (search_restart)
      begin
         core_next.shift       = CBW_WORD_RESET;
         core_next.beat_cnt    = CBW_CNT_RESET;
         core_next.width_found = 1'b0;
         core_next.sync_found  = 1'b0;
         if (serial_mode)
         begin
            // R10 skip width search
            core_next.state = CBW_ST_FIND_SYNC;
            core_next.width = CBW_W_X1;
         end
         else
         begin
            core_next.state = CBW_ST_FIND_MARK;
            core_next.width = CBW_W_X8;
         end
      end
      else if (beat_take)
      begin
         case (core_reg.state)
            CBW_ST_FIND_MARK:
            begin
               // R1 low lane only
               if (stream_word[7:0] == CBW_WIDTH_MARK)
               begin
                  core_next.state = CBW_ST_FIND_CODE;
               end
            end
            CBW_ST_FIND_CODE:
            begin
               // R2 R3 R4 width code after mark
               if (stream_word[7:0] == CBW_CODE_X8)
               begin
                  core_next.width       = CBW_W_X8;
                  core_next.width_found = 1'b1;
                  core_next.state       = CBW_ST_FIND_SYNC;
               end
               else if (stream_word[7:0] == CBW_CODE_X16)
               begin
                  core_next.width       = CBW_W_X16;
                  core_next.width_found = 1'b1;
                  core_next.state       = CBW_ST_FIND_SYNC;
               end
               else if (stream_word[7:0] == CBW_CODE_X32)
               begin
                  core_next.width       = CBW_W_X32;
                  core_next.width_found = 1'b1;
                  core_next.state       = CBW_ST_FIND_SYNC;
               end
               else if (stream_word[7:0] != CBW_WIDTH_MARK)
               begin
                  // R5 back to mark hunt
                  core_next.state = CBW_ST_FIND_MARK;
               end
               else
               begin
                  // A repeated mark may itself start the valid pair
                  core_next.state = CBW_ST_FIND_CODE;
               end
               // R6 fresh capture at new width
               core_next.shift = CBW_WORD_RESET;
            end
            CBW_ST_FIND_SYNC:
            begin
               // R6 R9 search runs only once width is known
               core_next.shift = shifted;
               // R7 sync word match
               if (shifted == CBW_SYNC_WORD)
               begin
                  core_next.sync_found = 1'b1;
                  core_next.beat_cnt   = CBW_CNT_RESET;
                  core_next.state      = CBW_ST_STREAM;
               end
            end
            CBW_ST_STREAM:
            begin
               // R8 words pass only after sync
               core_next.shift = shifted;
               if (core_reg.beat_cnt + 6'h01 == beats_needed)
               begin
                  core_next.beat_cnt   = CBW_CNT_RESET;
                  core_next.pend_word  = shifted;
                  core_next.pend_valid = 1'b1;
               end
               else
               begin
                  core_next.beat_cnt = core_reg.beat_cnt + 6'h01;
               end
            end
            default:
            begin
               core_next.state = CBW_ST_FIND_MARK;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         core_reg.state       <= CBW_ST_FIND_MARK;
         core_reg.width       <= CBW_W_X8;
         core_reg.clk_prev    <= 1'b0;
         core_reg.shift       <= CBW_WORD_RESET;
         core_reg.beat_cnt    <= CBW_CNT_RESET;
         core_reg.pend_word   <= CBW_WORD_RESET;
         core_reg.pend_valid  <= 1'b0;
         core_reg.width_found <= 1'b0;
         core_reg.sync_found  <= 1'b0;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // ---------------------------------------------------------------
   // Output buffer
   // ---------------------------------------------------------------
   // Two entries absorb one stall cycle of the receiver without loss
   cbw_buffer u_buffer (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_valid  (core_reg.pend_valid),
      .in_ready  (buf_ready),
      .in_data   (core_reg.pend_word),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_data)
   );

   // ---------------------------------------------------------------
   // Status outputs
   // ---------------------------------------------------------------
   assign width_found  = core_reg.width_found;
   assign bus_width    = core_reg.width;
   assign sync_found   = core_reg.sync_found;
   // Source may send another beat only while nothing is held back
   assign source_ready = !core_reg.pend_valid;

endmodule : cbw_detect

// ==== cbw_pkg.sv ====
// Purpose: Shared constants and types for the configuration bus width and sync word front end
// Assumes: 32-bit parallel data pins, byte lanes bit reversed at the pins
// Notes:   All patterns are held in stream (unswapped) bit order
package cbw_pkg;

   // ---------------------------------------------------------------
   // Stream patterns
   // ---------------------------------------------------------------
   localparam logic [7:0]  CBW_WIDTH_MARK  = 8'hbb;
   localparam logic [7:0]  CBW_CODE_X8     = 8'h11;
   localparam logic [7:0]  CBW_CODE_X16    = 8'h22;
   localparam logic [7:0]  CBW_CODE_X32    = 8'h44;
   localparam logic [31:0] CBW_SYNC_WORD   = 32'haa995566;

   // ---------------------------------------------------------------
   // Counts and reset values
   // ---------------------------------------------------------------
   localparam logic [5:0]  CBW_BEATS_X8    = 6'h04;
   localparam logic [5:0]  CBW_BEATS_X16   = 6'h02;
   localparam logic [5:0]  CBW_BEATS_X32   = 6'h01;
   localparam logic [5:0]  CBW_BEATS_X1    = 6'h20;
   localparam logic [5:0]  CBW_CNT_RESET   = 6'h00;
   localparam logic [31:0] CBW_WORD_RESET  = 32'h00000000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CBW_MODE_PARALLEL,
      CBW_MODE_MASTER_SERIAL,
      CBW_MODE_SLAVE_SERIAL,
      CBW_MODE_BOUNDARY_SCAN,
      CBW_MODE_SERIAL_FLASH
   } cbw_mode_type;

   typedef enum logic [1:0] {
      CBW_W_X8,
      CBW_W_X16,
      CBW_W_X32,
      CBW_W_X1
   } cbw_width_type;

   typedef enum logic [1:0] {
      CBW_ST_FIND_MARK,
      CBW_ST_FIND_CODE,
      CBW_ST_FIND_SYNC,
      CBW_ST_STREAM
   } cbw_state_type;

   typedef struct packed {
      logic [31:0] head;
      logic [31:0] tail;
      logic        head_valid;
      logic        tail_valid;
      logic        in_ready;
   } cbw_buf_type;

   typedef struct packed {
      cbw_state_type state;
      cbw_width_type width;
      logic          clk_prev;
      logic [31:0]   shift;
      logic [5:0]    beat_cnt;
      logic [31:0]   pend_word;
      logic          pend_valid;
      logic          width_found;
      logic          sync_found;
   } cbw_core_type;

endpackage : cbw_pkg

// ==== cbw_buffer.sv ====
// Purpose: Two-entry word buffer between the word assembler and the receiver
// Assumes: Single clock, synchronous active-high reset
// Notes:   in_ready and out_valid are flops, so a full buffer never drops a word
`timescale 1ns/1ps
module cbw_buffer
   import cbw_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Filling side
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [31:0] in_data,
   // Draining side
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [31:0]      out_data
);

   cbw_buf_type buf_reg;
   cbw_buf_type buf_next;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      buf_next = buf_reg;
      if (buf_reg.head_valid && out_ready)
      begin
         buf_next.head       = buf_reg.tail;
         buf_next.head_valid = buf_reg.tail_valid;
         buf_next.tail_valid = 1'b0;
      end
      if (in_valid && buf_reg.in_ready)
      begin
         if (!buf_next.head_valid)
         begin
            buf_next.head       = in_data;
            buf_next.head_valid = 1'b1;
         end
         else
         begin
            buf_next.tail       = in_data;
            buf_next.tail_valid = 1'b1;
         end
      end
      // Ready is decided a cycle early; a free tail slot is all it needs
      buf_next.in_ready = !buf_next.tail_valid;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         buf_reg.head       <= CBW_WORD_RESET;
         buf_reg.tail       <= CBW_WORD_RESET;
         buf_reg.head_valid <= 1'b0;
         buf_reg.tail_valid <= 1'b0;
         buf_reg.in_ready   <= 1'b1;
      end
      else
      begin
         buf_reg <= buf_next;
      end
   end

   assign in_ready  = buf_reg.in_ready;
   assign out_valid = buf_reg.head_valid;
   assign out_data  = buf_reg.head;

endmodule : cbw_buffer

// ==== cbw_checker.sv ====
// Purpose: Port-level checks for cbw_detect
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every cbw_detect instance
`timescale 1ns/1ps
module cbw_checker
   import cbw_pkg::*;
(
   // Clock and reset
   input wire logic          ref_clk,
   input wire logic          sys_rst,
   // Inputs of the block
   input wire cbw_mode_type  cfg_mode,
   input wire logic          search_restart,
   input wire logic          config_clock,
   input wire logic [31:0]   data_pins,
   input wire logic          word_ready,
   // Outputs of the block
   input wire logic          width_found,
   input wire cbw_width_type bus_width,
   input wire logic          sync_found,
   input wire logic          source_ready,
   input wire logic          word_valid,
   input wire logic [31:0]   word_data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------
   // Beat history, so causes are seen one edge back
   // ------------------------------------------------------------
   logic [7:0] lane_reg;
   logic       clk1_reg;
   logic       clk2_reg;
   always_ff @(posedge ref_clk)
   begin
      lane_reg <= data_pins[7:0];
      clk1_reg <= config_clock;
      clk2_reg <= clk1_reg;
   end
   chk_reset_idle: // Idle after reset
   assert property ($fell(sys_rst) |-> !width_found && !sync_found && !word_valid && source_ready)
      else $error("block not idle after reset");
   chk_width_code:
   assert property ($rose(width_found) |-> clk1_reg && !clk2_reg &&
      (lane_reg == 8'h88 && bus_width == CBW_W_X8 || lane_reg == 8'h44 && bus_width == CBW_W_X16 ||
       lane_reg == 8'h22 && bus_width == CBW_W_X32))
      else $error("width chosen without its code beat");
   chk_sync_code:
   assert property ($rose(sync_found) && bus_width != CBW_W_X1 |-> clk1_reg && !clk2_reg && lane_reg == 8'h66)
      else $error("sync found without its last beat");
   chk_no_early_word:
   assert property ($rose(word_valid) |-> sync_found)
      else $error("word offered before sync");
   chk_sync_needs_width:
   assert property (sync_found && bus_width != CBW_W_X1 |-> width_found)
      else $error("sync found before width");
   chk_width_holds:
   assert property (width_found && !search_restart |=> width_found && $stable(bus_width))
      else $error("width lost without restart");
   chk_serial_skip:
   assert property (search_restart && cfg_mode != CBW_MODE_PARALLEL |=>
      bus_width == CBW_W_X1 && !width_found && !sync_found)
      else $error("serial restart did not skip width");
   chk_word_hold: // Stalled word holds
   assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("stalled word changed");
   cov_x8: cover property ($rose(width_found) && bus_width == CBW_W_X8);
   cov_x32: cover property ($rose(width_found) && bus_width == CBW_W_X32);
   cov_serial: cover property ($rose(sync_found) && bus_width == CBW_W_X1);
   cov_full: cover property (!source_ready);
endmodule : cbw_checker

bind cbw_detect cbw_checker cbw_checker_inst (.ref_clk, .sys_rst, .cfg_mode, .search_restart, .config_clock,
   .data_pins, .word_ready, .width_found, .bus_width, .sync_found, .source_ready, .word_valid, .word_data);

// ==== cbw_source.sv ====
// Purpose: Model of the configuration source driving the data pins
// Assumes: Beats start at a falling edge of ref_clk
// Notes:   Pins show inverted data between beats, as a released bus would
`timescale 1ns/1ps
module cbw_source
   import cbw_pkg::*;
(
   // Clock and flow control
   input wire logic    ref_clk,
   input wire logic    source_ready,
   // Configuration pins
   output logic        config_clock,
   output logic [31:0] data_pins
);
   initial
   begin
      config_clock = 1'b0;
      data_pins    = 32'h0;
   end
   function automatic logic [31:0] swap(input logic [31:0] v);
      logic [31:0] r;
      for (int i = 0; i < 32; i++)
         r[i] = v[(i / 8) * 8 + 7 - (i % 8)];
      return r;
   endfunction : swap
   task automatic send(input logic [31:0] beat, input int gap);
      while (source_ready !== 1'b1)
         @(negedge ref_clk);
      data_pins    = swap(beat);
      config_clock = 1'b1;
      @(negedge ref_clk);
      config_clock = 1'b0;
      data_pins    = ~data_pins;
      repeat (gap + 1) @(negedge ref_clk);
   endtask : send
endmodule : cbw_source

// ==== test_config_bus_width_sync_detect.sv ====
// Purpose: Self-checking bench for the width and sync front end
// Assumes: Source model paces the beats, bench paces the receiver
// Notes:   Expected words wait in a queue until they leave the block
`timescale 1ns/1ps
module test_config_bus_width_sync_detect
   import cbw_pkg::*;
;
   logic          ref_clk, sys_rst, search_restart, word_ready, stall;
   logic          config_clock, width_found, sync_found, source_ready, word_valid;
   logic [31:0]   data_pins, word_data, junk;
   cbw_mode_type  cfg_mode;
   cbw_width_type bus_width;
   logic [31:0]   exp_q[$];
   int            failures, total_checks, cycles;
   integer        seed;
   cbw_detect cbw_detect_inst (.ref_clk, .sys_rst, .cfg_mode, .search_restart, .config_clock, .data_pins,
      .width_found, .bus_width, .sync_found, .source_ready, .word_valid, .word_ready, .word_data);
   cbw_source cbw_source_inst (.ref_clk, .source_ready, .config_clock, .data_pins);
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val
   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // Receiver stalls at random and matches every word leaving
   // ------------------------------------------------------------
   always @(negedge ref_clk)
   begin
      junk <= $random(seed);
      word_ready <= stall ? 1'b0 : junk[3];
   end
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (!sys_rst && word_valid === 1'b1 && word_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check_val("unexpected word", 32'h1, 32'h0);
         else
            check_val("word_data", exp_q.pop_front(), word_data);
      end
      // Ceiling is several times the whole test; a hang ends here as a failure
      if (cycles == 30000)
      begin
         failures++;
         close_out();
      end
   end
   // Upper lanes carry junk, in x1 the other low-lane pins are zero; only the beat bits count
   task automatic put(input logic [31:0] v, input int nb, input int bw);
      logic [31:0] b;
      logic [32:0] m;
      for (int i = 0; i < nb; i++)
      begin
         m = (bw == 1) ? 33'hff : (33'h1 << bw) - 33'h1;
         b = (v << (i * bw)) >> (32 - bw);
         if (bw == 1)
            b = {24'h0, b[0], 7'h0};
         cbw_source_inst.send((junk & ~m[31:0]) | b, junk[1:0]);
      end
   endtask : put
   task automatic run(input cbw_mode_type m, input int bw, input logic [7:0] code, input cbw_width_type w);
      logic [31:0] v;
      logic [7:0]  pat[6];
      cfg_mode = m;
      search_restart = 1'b1;
      @(negedge ref_clk);
      search_restart = 1'b0;
      pat = '{8'hff, 8'hbb, 8'h5a, 8'hbb, code, 8'hff};
      foreach (pat[i])
         put({pat[i], 24'h0}, bw == 1 ? 8 : 1, bw == 1 ? 1 : 8);
      check_val("width_found", {31'h0, m == CBW_MODE_PARALLEL}, {31'h0, width_found});
      check_val("bus_width", {30'h0, w}, {30'h0, bus_width});
      put(CBW_SYNC_WORD, 32 / bw, bw);
      check_val("sync_found", 32'h1, {31'h0, sync_found});
      stall = (bw == 32);
      for (int i = 0; i < 6; i++)
      begin
         v = $random(seed);
         exp_q.push_back(v);
         if (i == 3)
            stall = 1'b0;
         put(v, 32 / bw, bw);
      end
      for (int i = 0; i < 400 && (exp_q.size() > 0 || word_valid); i++)
         @(negedge ref_clk);
      check_val("words left", 32'h0, exp_q.size());
   endtask : run
   initial
   begin
      seed = 32'hd96efdaa;
      {sys_rst, search_restart, stall} = 3'b100;
      cfg_mode = CBW_MODE_PARALLEL;
      failures = 0;
      total_checks = 0;
      repeat (6) @(negedge ref_clk);
      sys_rst = 1'b0;
      // Byte-wide sync before any width pair: a premature search would match it
      put(CBW_SYNC_WORD, 4, 8);
      check_val("early sync", 32'h0, {31'h0, sync_found});
      run(CBW_MODE_PARALLEL, 8, CBW_CODE_X8, CBW_W_X8);
      run(CBW_MODE_PARALLEL, 16, CBW_CODE_X16, CBW_W_X16);
      run(CBW_MODE_PARALLEL, 32, CBW_CODE_X32, CBW_W_X32);
      for (int k = 1; k < 5; k++)
         run(cbw_mode_type'(k), 1, CBW_CODE_X8, CBW_W_X1);
      close_out();
   end
endmodule : test_config_bus_width_sync_detect
